// >>> rtl/ppp_pkg.sv
// Package with constants and types shared by both ends of the programming port.
package ppp_pkg;
  // Action codes selected by the two action-select pins.
  localparam logic [1:0] ACT_ADDR = 2'b00;
  localparam logic [1:0] ACT_DATA = 2'b01;
  localparam logic [1:0] ACT_CMD  = 2'b10;
  localparam logic [1:0] ACT_IDLE = 2'b11;
  // Command bytes.
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM  = 8'h03;
  // Memory geometry.
  localparam int FL_WORD_BITS = 6;
  localparam int FL_PAGE_BITS = 7;
  localparam int FL_ADDR_BITS = FL_WORD_BITS + FL_PAGE_BITS;
  localparam int EE_BYTE_BITS = 2;
  localparam int EE_PAGE_BITS = 7;
  localparam int EE_ADDR_BITS = EE_BYTE_BITS + EE_PAGE_BITS;
  // Fuse layout and reset values.
  localparam int FUSE_PRESERVE_BIT = 3;
  localparam logic [7:0] FUSE_LO_RST  = 8'hE1;
  localparam logic [7:0] FUSE_HI_RST  = 8'h99;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST     = 8'hFF;
  localparam logic [7:0] ERASED_BYTE  = 8'hFF;
  // Signature identity bytes; values are arbitrary.
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'h21;
  localparam logic [7:0] SIG_BYTE2 = 8'h07;
  localparam int SIG_COUNT  = 3;
  localparam int TRIM_COUNT = 4;
  // Busy time of a write-type command, in step-clock-free system cycles.
  localparam int BUSY_NS = 1000;
  localparam int CLK_NS  = 50;
  localparam int BUSY_CYCLES = (BUSY_NS + CLK_NS - 1) / CLK_NS;
  // Host clock divider for the step clock pin: half period in cycles.
  localparam int STEP_HALF_NS = 200;
  localparam int STEP_HALF_CYCLES = STEP_HALF_NS / CLK_NS;
  // Host operations.
  typedef enum logic [2:0] {
    PPP_OP_LOAD   = 3'h0,
    PPP_OP_WRITE  = 3'h1,
    PPP_OP_READ   = 3'h2,
    PPP_OP_PAGE   = 3'h3,
    PPP_OP_ENTER  = 3'h4,
    PPP_OP_EXIT   = 3'h5
  } ppp_op_t;
endpackage : ppp_pkg

// >>> rtl/ppp_if.sv
// Interface with the parallel programming pins joining programmer and device.
`timescale 1ns/1ps
interface ppp_if;
  logic       step_clock_pin;
  logic       action_select_lo;
  logic       action_select_hi;
  logic       byte_select_first;
  logic       byte_select_second;
  logic       page_load_strobe;
  logic       write_strobe_n;
  logic       output_enable_n;
  logic       prog_reset_n;
  logic       progress_flag;
  logic [7:0] data_host_o;
  logic [7:0] data_dev_o;
  logic       data_dev_oe;
  logic [7:0] data_bus;
  assign data_bus = data_dev_oe ? data_dev_o : data_host_o;
  modport device (
    input  step_clock_pin, action_select_lo, action_select_hi, byte_select_first, byte_select_second,
    input  page_load_strobe, write_strobe_n, output_enable_n, prog_reset_n, data_bus,
    output progress_flag, data_dev_o, data_dev_oe
  );
  modport host (
    output step_clock_pin, action_select_lo, action_select_hi, byte_select_first, byte_select_second,
    output page_load_strobe, write_strobe_n, output_enable_n, prog_reset_n, data_host_o,
    input  progress_flag, data_bus
  );
endinterface : ppp_if

// >>> rtl/ppp_device.sv
// Device end of the parallel programming port with its memories and fuses.
// Functional notes
// - Fuses latched on programming mode entry.
// - Preserve-EEPROM fuse acts immediately when programmed.
// - Fuses also latched at normal power-up.
// - Programmer writes fuses before lock bits.
// - Three identity bytes, readable when locked.
// - Four trim bytes in signature high bytes.
// - Reset copies lowest-frequency trim into register.
// - Flash: 128 pages of 64 words.
// - EEPROM: 128 pages of 4 bytes.
// - Step clock pulse action chosen by selects.
// - First byte select steers address byte.
// - First byte select steers flash data byte.
// - Write strobe and output enable execute the last loaded command; page load strobe does not.
// - Decode write-type command bytes.
// - Decode read-type command bytes.
// - Progress flag low while busy.
// - Drive data bus only while output enable low.
// - Second byte select picks extended high byte.
// - Page load strobe fills the page buffer.
// - Entry needs four qualifier pins low.
// - Reset low and six step pulses first.
// - Command and address retained across operations.
`timescale 1ns/1ps
module ppp_device #(
  parameter int BUSY_CYCLES = ppp_pkg::BUSY_CYCLES
) (
  // System.
  input  wire logic       clk,
  input  wire logic       reset,
  // Programming pins.
  ppp_if.device           pins,
  // User side.
  output logic            prog_mode,
  output logic [7:0]      rc_trim_register,
  output logic [7:0]      fuse_lo_active,
  output logic [7:0]      fuse_hi_active,
  output logic            preserve_eeprom_fuse
);
  localparam int FLW = 1 << ppp_pkg::FL_ADDR_BITS;
  localparam int EEW = 1 << ppp_pkg::EE_ADDR_BITS;

  // Two-flip-flop synchronisers for every pin input.
  localparam int NS = 8;
  logic [NS-1:0] s1_q, s2_q, s3_q;
  logic [7:0]    d1_q, d2_q;
  wire  [NS-1:0] raw = {pins.step_clock_pin, pins.output_enable_n, pins.write_strobe_n,
                        pins.page_load_strobe, pins.byte_select_second, pins.byte_select_first,
                        pins.action_select_hi, pins.action_select_lo};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      d1_q <= pins.data_bus;
      d2_q <= d1_q;
    end
  end
  // The reset qualifier is synchronised separately.
  logic rn1_q, rn2_q, rn3_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rn1_q <= 1'b0;
      rn2_q <= 1'b0;
      rn3_q <= 1'b0;
    end else begin
      rn1_q <= pins.prog_reset_n;
      rn2_q <= rn1_q;
      rn3_q <= rn2_q;
    end
  end
  wire       step_rise = s2_q[7] & ~s3_q[7];
  wire [1:0] act       = {s2_q[1], s2_q[0]};
  wire       bs1       = s2_q[2];
  wire       bs2       = s2_q[3];
  wire       page_rise = s2_q[4] & ~s3_q[4];
  wire       wr_fall   = ~s2_q[5] & s3_q[5];
  wire       oe_n      = s2_q[6];
  wire       entry_rise = rn2_q & ~rn3_q;

  // Entry: qualifier pins all low at reset release.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_mode <= 1'b0;
    end else if (!rn2_q) begin
      prog_mode <= 1'b0;
    end else if (entry_rise) begin
      prog_mode <= ({s2_q[4], s2_q[1], s2_q[0], s2_q[2]} == 4'h0);
    end
  end

  // Holding registers.
  logic [7:0] cmd_q, addr_lo_q, addr_hi_q, data_lo_q, data_hi_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_q     <= 8'h00;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      data_lo_q <= 8'h00;
      data_hi_q <= 8'h00;
    end else if (prog_mode && step_rise) begin
      case (act)
        ppp_pkg::ACT_ADDR: if (bs1) addr_hi_q <= d2_q; else addr_lo_q <= d2_q;
        ppp_pkg::ACT_DATA: if (bs1) data_hi_q <= d2_q; else data_lo_q <= d2_q;
        ppp_pkg::ACT_CMD:  cmd_q <= d2_q;
        default: ;
      endcase
    end
  end
  wire [15:0] addr = {addr_hi_q, addr_lo_q};
  wire [ppp_pkg::FL_WORD_BITS-1:0] in_page_word_index = addr[ppp_pkg::FL_WORD_BITS-1:0];
  wire [ppp_pkg::FL_PAGE_BITS-1:0] page_index = addr[ppp_pkg::FL_ADDR_BITS-1:ppp_pkg::FL_WORD_BITS];
  wire [ppp_pkg::EE_ADDR_BITS-1:0] eeprom_address = addr[ppp_pkg::EE_ADDR_BITS-1:0];
  wire [ppp_pkg::EE_BYTE_BITS-1:0] ee_in_page = eeprom_address[ppp_pkg::EE_BYTE_BITS-1:0];

  // Memories and page buffers.
  logic [15:0] flash_mem [FLW];
  logic [7:0]  ee_mem    [EEW];
  logic [15:0] fl_buf    [1 << ppp_pkg::FL_WORD_BITS];
  logic [7:0]  ee_buf    [1 << ppp_pkg::EE_BYTE_BITS];
  logic [7:0]  fuse_lo_q, fuse_hi_q, fuse_ext_q, lock_q;
  logic        busy_q;
  logic [7:0]  cnt_q;
  wire         locked = (lock_q[1:0] != 2'b11);

  always_ff @(posedge clk) begin
    if (prog_mode && page_rise) begin
      fl_buf[in_page_word_index] <= {data_hi_q, data_lo_q};
      ee_buf[ee_in_page] <= data_lo_q;
    end
  end

  // Write-type commands on a write strobe, ignored while busy.
  wire do_write = prog_mode && wr_fall && !busy_q;
  always_ff @(posedge clk) begin
    if (do_write) begin
      case (cmd_q)
        ppp_pkg::CMD_CHIP_ERASE: begin
          for (int i = 0; i < FLW; i++) flash_mem[i] <= {2{ppp_pkg::ERASED_BYTE}};
          if (!preserve_eeprom_fuse) begin
            for (int i = 0; i < EEW; i++) ee_mem[i] <= ppp_pkg::ERASED_BYTE;
          end
        end
        ppp_pkg::CMD_WR_FLASH:
          for (int i = 0; i < (1 << ppp_pkg::FL_WORD_BITS); i++)
            flash_mem[{page_index, i[ppp_pkg::FL_WORD_BITS-1:0]}] <= fl_buf[i];
        ppp_pkg::CMD_WR_EEPROM:
          for (int i = 0; i < (1 << ppp_pkg::EE_BYTE_BITS); i++)
            ee_mem[{eeprom_address[ppp_pkg::EE_ADDR_BITS-1:ppp_pkg::EE_BYTE_BITS],
                    i[ppp_pkg::EE_BYTE_BITS-1:0]}] <= ee_buf[i];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuse_lo_q  <= ppp_pkg::FUSE_LO_RST;
      fuse_hi_q  <= ppp_pkg::FUSE_HI_RST;
      fuse_ext_q <= ppp_pkg::FUSE_EXT_RST;
      lock_q     <= ppp_pkg::LOCK_RST;
    end else if (do_write) begin
      if (cmd_q == ppp_pkg::CMD_CHIP_ERASE) begin
        lock_q <= ppp_pkg::LOCK_RST;
      end else if (cmd_q == ppp_pkg::CMD_WR_LOCK) begin
        lock_q <= lock_q & data_lo_q;
      end else if (cmd_q == ppp_pkg::CMD_WR_FUSE && !locked) begin
        if (!bs1 && !bs2) fuse_lo_q <= data_lo_q;
        else if (bs1 && !bs2) fuse_hi_q <= data_lo_q;
        else if (bs2) fuse_ext_q <= data_lo_q;
      end
    end
  end

  // Active fuses: latched at entry and at normal power-up.
  logic norm_seen_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fuse_lo_active <= ppp_pkg::FUSE_LO_RST;
      fuse_hi_active <= ppp_pkg::FUSE_HI_RST;
      norm_seen_q    <= 1'b0;
    end else if (entry_rise || !norm_seen_q) begin
      fuse_lo_active <= fuse_lo_q;
      fuse_hi_active <= fuse_hi_q;
      norm_seen_q    <= 1'b1;
    end
  end
  assign preserve_eeprom_fuse = ~fuse_hi_q[ppp_pkg::FUSE_PRESERVE_BIT];

  // Signature row: identity bytes low, trim values high.
  logic [7:0] trim_q [ppp_pkg::TRIM_COUNT];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ppp_pkg::TRIM_COUNT; i++) trim_q[i] <= 8'h80 - 8'(i);
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) rc_trim_register <= 8'h00;
    else if (!norm_seen_q) rc_trim_register <= trim_q[0];
  end
  function automatic logic [7:0] sig_byte(input logic [1:0] a);
    case (a)
      2'd0: sig_byte = ppp_pkg::SIG_BYTE0;
      2'd1: sig_byte = ppp_pkg::SIG_BYTE1;
      2'd2: sig_byte = ppp_pkg::SIG_BYTE2;
      default: sig_byte = ppp_pkg::ERASED_BYTE;
    endcase
  endfunction : sig_byte

  // Busy timer.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (do_write) begin
      busy_q <= 1'b1;
      cnt_q  <= 8'(BUSY_CYCLES);
    end else if (busy_q) begin
      cnt_q  <= cnt_q - 8'h01;
      busy_q <= (cnt_q != 8'h01);
    end
  end
  assign pins.progress_flag = ~busy_q;

  // Read path.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins.data_dev_o <= 8'h00;
    end else begin
      case (cmd_q)
        ppp_pkg::CMD_RD_SIG:
          pins.data_dev_o <= bs1 ? trim_q[addr[1:0]] : sig_byte(addr[1:0]);
        ppp_pkg::CMD_RD_FUSE:
          pins.data_dev_o <= bs2 ? (bs1 ? fuse_hi_q : fuse_ext_q) : (bs1 ? lock_q : fuse_lo_q);
        ppp_pkg::CMD_RD_FLASH: begin
          logic [15:0] w;
          w = flash_mem[addr[ppp_pkg::FL_ADDR_BITS-1:0]];
          pins.data_dev_o <= locked ? ppp_pkg::ERASED_BYTE : (bs1 ? w[15:8] : w[7:0]);
        end
        ppp_pkg::CMD_RD_EEPROM:
          pins.data_dev_o <= locked ? ppp_pkg::ERASED_BYTE : ee_mem[eeprom_address];
        default: pins.data_dev_o <= 8'h00;
      endcase
    end
  end
  assign pins.data_dev_oe = prog_mode && !oe_n && !busy_q;
endmodule : ppp_device

// >>> rtl/ppp_host.sv
// Programmer end: APB-driven pin sequencer for the parallel programming port.
`timescale 1ns/1ps
module ppp_host (
  // System.
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Programming pins.
  ppp_if.host              pins
);
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RDATA  = 12'h008;

  typedef enum logic [4:0] {
    H_IDLE = 5'b00001, H_SETUP = 5'b00010, H_HI = 5'b00100, H_LO = 5'b01000, H_WAIT = 5'b10000
  } ppp_hst_t;
  ppp_hst_t st_q;
  logic [2:0] div_q;
  logic [2:0] op_q;
  logic [7:0] rdata_q;
  logic [2:0] phase_q;
  logic       rdy1_q, rdy2_q;
  logic [7:0] db1_q, db2_q;
  wire  tick = (div_q == 3'(ppp_pkg::STEP_HALF_CYCLES - 1));
  wire  wr   = psel && penable && pwrite;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdy1_q <= 1'b0; rdy2_q <= 1'b0; db1_q <= 8'h00; db2_q <= 8'h00;
    end else begin
      rdy1_q <= pins.progress_flag; rdy2_q <= rdy1_q; db1_q <= pins.data_bus; db2_q <= db1_q;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) div_q <= 3'h0;
    else div_q <= tick ? 3'h0 : div_q + 3'h1;
  end

  // Command word: [2:0] op, [4:3] action, [5] first select, [6] second select, [15:8] data.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= H_IDLE; op_q <= 3'h0; phase_q <= 3'h0; rdata_q <= 8'h00;
      pins.step_clock_pin <= 1'b0; pins.action_select_lo <= 1'b1; pins.action_select_hi <= 1'b1;
      pins.byte_select_first <= 1'b0; pins.byte_select_second <= 1'b0; pins.page_load_strobe <= 1'b0;
      pins.write_strobe_n <= 1'b1; pins.output_enable_n <= 1'b1; pins.prog_reset_n <= 1'b0;
      pins.data_host_o <= 8'h00;
    end else begin
      case (st_q)
        H_IDLE: if (wr && paddr == REG_CMD) begin
          op_q <= pwdata[2:0];
          {pins.action_select_hi, pins.action_select_lo} <= pwdata[4:3];
          pins.byte_select_first <= pwdata[5];
          pins.byte_select_second <= pwdata[6];
          pins.data_host_o <= pwdata[15:8];
          phase_q <= 3'h0;
          st_q <= H_SETUP;
        end
        H_SETUP: if (tick) begin
          st_q <= H_HI;
          case (ppp_pkg::ppp_op_t'(op_q))
            ppp_pkg::PPP_OP_LOAD:  pins.step_clock_pin <= 1'b1;
            ppp_pkg::PPP_OP_WRITE: pins.write_strobe_n <= 1'b0;
            ppp_pkg::PPP_OP_READ:  pins.output_enable_n <= 1'b0;
            ppp_pkg::PPP_OP_PAGE:  pins.page_load_strobe <= 1'b1;
            ppp_pkg::PPP_OP_ENTER: begin
              pins.step_clock_pin <= 1'b1;
              pins.page_load_strobe <= 1'b0; pins.action_select_hi <= 1'b0;
              pins.action_select_lo <= 1'b0; pins.byte_select_first <= 1'b0;
            end
            ppp_pkg::PPP_OP_EXIT:  pins.prog_reset_n <= 1'b0;
            default: st_q <= H_IDLE;
          endcase
        end
        H_HI: if (tick) begin
          st_q <= H_LO;
          pins.step_clock_pin <= 1'b0; pins.write_strobe_n <= 1'b1;
          pins.output_enable_n <= 1'b1; pins.page_load_strobe <= 1'b0;
        end
        H_LO: begin
          // Read data is taken one cycle after the strobe is released, while the synchronised bus still shows it.
          if (op_q == 3'(ppp_pkg::PPP_OP_READ) && div_q == 3'h0) rdata_q <= db2_q;
          if (tick) begin
          if (op_q == 3'(ppp_pkg::PPP_OP_ENTER) && phase_q != 3'h5) begin
            phase_q <= phase_q + 3'h1;
            pins.step_clock_pin <= 1'b1;
            st_q <= H_HI;
          end else begin
            if (op_q == 3'(ppp_pkg::PPP_OP_ENTER)) pins.prog_reset_n <= 1'b1;
            st_q <= H_WAIT;
          end
          end
        end
        H_WAIT: if (tick && rdy2_q) st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    case (paddr)
      REG_STATUS: prdata = {31'h0000_0000, st_q != H_IDLE};
      REG_RDATA:  prdata = {24'h00_0000, rdata_q};
      default:    prdata = 32'h0000_0000;
    endcase
  end
endmodule : ppp_host

// >>> bench/ppp_chk.sv
// Checker of the programming pins between programmer and device.
`timescale 1ns/1ps
module ppp_chk (
  // System.
  input wire logic       clk,
  input wire logic       reset,
  // Programming pins.
  input wire logic       step_clock_pin,
  input wire logic       action_select_lo,
  input wire logic       action_select_hi,
  input wire logic       byte_select_first,
  input wire logic       page_load_strobe,
  input wire logic       write_strobe_n,
  input wire logic       output_enable_n,
  input wire logic       prog_reset_n,
  input wire logic       progress_flag,
  input wire logic       data_dev_oe,
  input wire logic [7:0] data_bus
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [3:0] steps_q;
  logic [5:0] wr_age_q;
  // Counts step pulses while reset is held and cycles since the last write strobe.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      steps_q <= 4'h0;
    end else if (prog_reset_n) begin
      steps_q <= 4'h0;
    end else if ($rose(step_clock_pin) && steps_q != 4'hF) begin
      steps_q <= steps_q + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_age_q <= 6'h3F;
    end else if (!write_strobe_n) begin
      wr_age_q <= 6'h00;
    end else if (wr_age_q != 6'h3F) begin
      wr_age_q <= wr_age_q + 6'h01;
    end
  end
  sequence step_high_s;
    step_clock_pin [*4] ##1 !step_clock_pin;
  endsequence
  sequence busy_s;
    !progress_flag [*8];
  endsequence
  AST_STEP_PULSE: assert property ($rose(step_clock_pin) |-> step_high_s)
    else $error("step pulse width wrong");
  AST_STEP_STABLE: assert property ($rose(step_clock_pin) |->
    $stable({action_select_hi, action_select_lo, byte_select_first}) && (!prog_reset_n || $stable(data_bus)))
    else $error("selects or data moved at step edge");
  AST_BUSY_HOLD: assert property ($fell(progress_flag) |-> busy_s)
    else $error("busy too short");
  AST_BUSY_END: assert property ($fell(progress_flag) |-> ##[1:40] progress_flag)
    else $error("busy never ended");
  AST_BUSY_CAUSE: assert property ($fell(progress_flag) |-> wr_age_q < 6'h20)
    else $error("busy without write strobe");
  AST_WR_READY: assert property ($fell(write_strobe_n) |-> progress_flag)
    else $error("write strobe while busy");
  AST_OE_ONLY: assert property (data_dev_oe |-> (!output_enable_n || !$past(output_enable_n) ||
    !$past(output_enable_n, 2) || !$past(output_enable_n, 3)))
    else $error("device drives bus without output enable");
  AST_OE_PROG: assert property (data_dev_oe |-> prog_reset_n)
    else $error("device drives bus outside programming mode");
  AST_BUSY_NO_OE: assert property (!progress_flag |-> !data_dev_oe)
    else $error("device drives bus while busy");
  AST_ENTRY_QUAL: assert property ($rose(prog_reset_n) |->
    {page_load_strobe, action_select_hi, action_select_lo, byte_select_first} == 4'h0)
    else $error("entry qualifier not low");
  AST_ENTRY_STEPS: assert property ($rose(prog_reset_n) |-> steps_q >= 4'h6)
    else $error("too few step pulses before entry");
endmodule : ppp_chk

// >>> bench/parallel_program_port_bench.sv
// Testbench of programmer and device joined over the programming pins.
`timescale 1ns/1ps
module parallel_program_port_bench;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, prog_mode, preserve_eeprom_fuse;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rc_trim_register, fuse_lo_active, fuse_hi_active, dlo, dhi, ee_dat;
  logic [12:0] fl_addr;
  logic [8:0]  ee_addr;
  integer      seed;
  int          err_total, total_checks;
  ppp_if pif ();
  ppp_host ppp_host_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pif.host));
  ppp_device #(.BUSY_CYCLES(20)) ppp_device_inst (.clk(clk), .reset(reset), .pins(pif.device),
    .prog_mode(prog_mode), .rc_trim_register(rc_trim_register), .fuse_lo_active(fuse_lo_active),
    .fuse_hi_active(fuse_hi_active), .preserve_eeprom_fuse(preserve_eeprom_fuse));
  ppp_chk ppp_chk_inst (.clk(clk), .reset(reset), .step_clock_pin(pif.step_clock_pin),
    .action_select_lo(pif.action_select_lo), .action_select_hi(pif.action_select_hi),
    .byte_select_first(pif.byte_select_first), .page_load_strobe(pif.page_load_strobe),
    .write_strobe_n(pif.write_strobe_n), .output_enable_n(pif.output_enable_n),
    .prog_reset_n(pif.prog_reset_n), .progress_flag(pif.progress_flag), .data_dev_oe(pif.data_dev_oe),
    .data_bus(pif.data_bus));
  always #25 clk = ~clk;
  function automatic logic [7:0] sig_exp(input int i);
    return (i == 0) ? ppp_pkg::SIG_BYTE0 : (i == 1) ? ppp_pkg::SIG_BYTE1 : ppp_pkg::SIG_BYTE2;
  endfunction : sig_exp
  function automatic logic [7:0] trim_exp(input int i);
    return 8'h80 - 8'(i);
  endfunction : trim_exp
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic op(input logic [2:0] o, input logic [1:0] act, input logic f, input logic s, input logic [7:0] b);
    logic [31:0] r;
    int n;
    apb(1'b1, 12'h000, {16'h0000, b, 1'b0, s, f, act, o}, r);
    r = 32'h0000_0001;
    n = 0;
    while (r[0] !== 1'b0 && n < 400) begin
      apb(1'b0, 12'h004, 32'h0000_0000, r);
      n++;
    end
  endtask : op
  task automatic ld(input logic [1:0] act, input logic f, input logic [7:0] b);
    op(ppp_pkg::PPP_OP_LOAD, act, f, 1'b0, b);
  endtask : ld
  task automatic ld_addr(input logic [12:0] a);
    ld(ppp_pkg::ACT_ADDR, 1'b0, a[7:0]);
    ld(ppp_pkg::ACT_ADDR, 1'b1, {3'b000, a[12:8]});
  endtask : ld_addr
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", name, e, g);
      err_total++;
    end
  endtask : chk
  task automatic chk_rd(input string name, input logic f, input logic s, input logic [7:0] e);
    logic [31:0] r;
    op(ppp_pkg::PPP_OP_READ, ppp_pkg::ACT_IDLE, f, s, 8'h00);
    apb(1'b0, 12'h008, 32'h0000_0000, r);
    chk(name, e, r[7:0]);
  endtask : chk_rd
  task automatic wr(input logic f, input logic s);
    op(ppp_pkg::PPP_OP_WRITE, ppp_pkg::ACT_IDLE, f, s, 8'h00);
  endtask : wr
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end
  initial begin
    clk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; seed = 32'h0000_24d2; err_total = 0; total_checks = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    chk("prog_mode", 8'h00, {7'h00, prog_mode});
    chk("progress_flag", 8'h01, {7'h00, pif.progress_flag});
    chk("rc_trim", trim_exp(0), rc_trim_register);
    chk("fuse_lo", ppp_pkg::FUSE_LO_RST, fuse_lo_active);
    $display("test reset done");
    op(ppp_pkg::PPP_OP_ENTER, ppp_pkg::ACT_ADDR, 1'b0, 1'b0, 8'h00);
    chk("prog_mode", 8'h01, {7'h00, prog_mode});
    chk("fuse_hi", ppp_pkg::FUSE_HI_RST, fuse_hi_active);
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
    ld_addr(13'h0000);
    for (int i = 0; i < 4; i++) begin
      ld(ppp_pkg::ACT_ADDR, 1'b0, 8'(i));
      if (i < 3) chk_rd("signature", 1'b0, 1'b0, sig_exp(i));
      chk_rd("trim", 1'b1, 1'b0, trim_exp(i));
    end
    $display("test signature done");
    for (int i = 0; i < 5; i++) begin
      fl_addr = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : 13'($random(seed));
      dlo = 8'($random(seed));
      dhi = 8'($random(seed));
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FLASH);
      ld_addr(fl_addr);
      ld(ppp_pkg::ACT_DATA, 1'b0, dlo);
      ld(ppp_pkg::ACT_DATA, 1'b1, dhi);
      op(ppp_pkg::PPP_OP_PAGE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      wr(1'b0, 1'b0);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
      chk_rd("flash_lo", 1'b0, 1'b0, dlo);
      chk_rd("flash_hi", 1'b1, 1'b0, dhi);
    end
    $display("test flash done");
    for (int i = 0; i < 4; i++) begin
      ee_addr = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      ee_dat = 8'($random(seed));
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_EEPROM);
      ld_addr({4'h0, ee_addr});
      ld(ppp_pkg::ACT_DATA, 1'b0, ee_dat);
      op(ppp_pkg::PPP_OP_PAGE, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
      wr(1'b0, 1'b0);
      ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEPROM);
      chk_rd("eeprom", 1'b0, 1'b0, ee_dat);
    end
    $display("test eeprom done");
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'hA5);
    wr(1'b0, 1'b0);
    chk("fuse_lo", ppp_pkg::FUSE_LO_RST, fuse_lo_active);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h91);
    wr(1'b1, 1'b0);
    chk("preserve", 8'h01, {7'h00, preserve_eeprom_fuse});
    chk("fuse_hi", ppp_pkg::FUSE_HI_RST, fuse_hi_active);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'h3C);
    wr(1'b0, 1'b1);
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
    chk_rd("fuse_rd", 1'b0, 1'b0, 8'hA5);
    chk_rd("fuse_ext", 1'b0, 1'b1, 8'h3C);
    op(ppp_pkg::PPP_OP_EXIT, ppp_pkg::ACT_IDLE, 1'b0, 1'b0, 8'h00);
    chk("prog_mode", 8'h00, {7'h00, prog_mode});
    op(ppp_pkg::PPP_OP_ENTER, ppp_pkg::ACT_ADDR, 1'b0, 1'b0, 8'h00);
    chk("fuse_lo", 8'hA5, fuse_lo_active);
    chk("fuse_hi", 8'h91, fuse_hi_active);
    $display("test fuse done");
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_LOCK);
    ld(ppp_pkg::ACT_DATA, 1'b0, 8'hFC);
    wr(1'b0, 1'b0);
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
    ld_addr(13'h0002);
    chk_rd("locked_sig", 1'b0, 1'b0, sig_exp(2));
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_CHIP_ERASE);
    wr(1'b0, 1'b0);
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
    ld_addr(fl_addr);
    chk_rd("erased_flash", 1'b0, 1'b0, ppp_pkg::ERASED_BYTE);
    ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEPROM);
    ld_addr({4'h0, ee_addr});
    chk_rd("kept_eeprom", 1'b0, 1'b0, ee_dat);
    $display("test lock and erase done");
    test_done();
  end
endmodule : parallel_program_port_bench
